// ---- rtl/fault_framer_pkg.sv ----
// Package with constants and types for the emergency frame builder.
package fault_framer_pkg;
    localparam logic [10:0] EMCY_BASE_ID = 11'h080;
    localparam logic [15:0] CODE_CAN_COMM = 16'h8100;
    localparam logic [15:0] CODE_OVERRUN = 16'h8110;
    localparam logic [15:0] CODE_GUARD = 16'h8130;
    localparam logic [15:0] CODE_RPDO_SHORT = 16'h8210;
    localparam logic [15:0] CODE_ADC = 16'h5000;
    localparam logic [7:0] TOGGLE_OFF = 8'h00;
    localparam logic [7:0] TOGGLE_ON = 8'h80;
    localparam logic [7:0] ADC_FRONTEND_BASE = 8'h60;
    localparam logic [7:0] SUB_CONV = 8'h01;
    localparam logic [7:0] SUB_RESET = 8'h02;
    localparam logic [7:0] SUB_OFFSET = 8'h03;
    localparam logic [7:0] SUB_GAIN = 8'h04;
    localparam logic [7:0] SUB_INIT = 8'h05;
    // Reset error identifier flags.
    localparam logic [7:0] RSTERR_VALID_NOT_SET = 8'h01;
    localparam logic [7:0] RSTERR_VALID_NOT_CLEARED = 8'h02;
    localparam logic [7:0] RSTERR_BAD_OFFSET = 8'h04;
    localparam logic [7:0] RSTERR_BAD_GAIN = 8'h08;
    // CAN controller interrupt flag bits.
    localparam logic [7:0] CANINT_WARNING = 8'h04;
    localparam logic [7:0] CANINT_BUS_OFF = 8'h20;
    localparam logic [7:0] CANINT_ERR_PASSIVE = 8'h40;
    localparam logic [7:0] CANINT_TX_CHECK = 8'h80;
    localparam logic [7:0] CANINT_MASK = 8'hE4;
    // CAN controller mode and status bits.
    localparam logic [7:0] CANMODE_INIT = 8'h01;
    localparam logic [7:0] CANMODE_RESET = 8'h02;
    localparam logic [7:0] CANMODE_BUS_OFF = 8'h04;
    localparam logic [7:0] CANMODE_RX_ERR96 = 8'h08;
    localparam logic [7:0] CANMODE_TX_ERR96 = 8'h10;
    localparam logic [7:0] CANMODE_TX_DONE = 8'h20;
    localparam logic [7:0] CANMODE_RX_MODE = 8'h40;
    localparam logic [7:0] CANMODE_AUTO_DEC = 8'h80;
    localparam logic [7:0] ERR_COUNT_LIMIT = 8'd96;
    // Register indices on the local port.
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK = 4'h1;
    localparam logic [3:0] REG_NODE = 4'h2;
    localparam logic [3:0] REG_COUNT = 4'h3;
    localparam logic [3:0] REG_LAST_CODE = 4'h4;
    localparam logic [7:0] NODE_RESET = 8'h01;
    localparam int EVENT_COUNT = 9;
    localparam int EV_CAN = 0;
    localparam int EV_OVERRUN = 1;
    localparam int EV_GUARD = 2;
    localparam int EV_RPDO = 3;
    localparam int EV_ADC_CONV = 4;
    localparam int EV_ADC_RESET = 5;
    localparam int EV_ADC_OFFSET = 6;
    localparam int EV_ADC_GAIN = 7;
    localparam int EV_ADC_INIT = 8;

    typedef struct packed {
        logic [7:0] int_flags;
        logic [7:0] mode_status;
        logic [7:0] error_count;
        logic [7:0] busoff_count;
    } can_fault_type;

    typedef struct packed {
        logic frontend;
        logic [7:0] channel;
        logic [7:0] detail;
    } adc_fault_type;

    typedef struct packed {
        logic [10:0] id;
        logic [7:0][7:0] data;
    } frame_type;

    typedef enum logic [1:0] {
        IDLE,
        SEND
    } phase_type;

    typedef struct packed {
        phase_type phase;
        frame_type frame;
        logic frame_valid;
        logic toggle;
        logic can_reinit;
        logic [EVENT_COUNT-1:0] status;
        logic [EVENT_COUNT-1:0] mask;
        logic [7:0] node;
        logic [15:0] count;
        logic [15:0] last_code;
        logic [31:0] rdata;
        logic irq;
    } state_type;
endpackage

// ---- rtl/fault_message_framer.sv ----
// Emergency frame builder for internal fault events of a fieldbus node.
// Operation
// - Frame identifier is base 080h plus the node number.
// - Bytes 0-1 error code, byte 2 error register, bytes 3-6 detail.
// - Byte 7 alternates 00h and 80h with every frame sent.
// - Frames are only produced by a detected error event.
// - CAN fault uses 8100 with interrupt, mode, error and bus-off bytes.
// - Receive buffer overrun with message loss uses code 8110h.
// - Life-guard time-out reinitialises the CAN controller, code 8130; CAN_REINIT_O pulses only when the guard frame is built.
// - Short process-data frame uses 8210, minimum DLC in byte 3.
// - ADC conversion time-out: 5000, 01h/61h, channel, zero.
// - ADC reset failure: 5000, 02h/62h, zero, reset error id.
// - ADC offset calibration failure: 5000, 03h/63h, zero.
// - ADC gain calibration failure: 5000, 04h/64h, zero.
// - ADC initialisation problem: 5000, 05h/65h, ADC status.
// - Reset error id flags are 01, 02, 04 and 08.
// - CAN interrupt byte bits 04h, 20h, 40h, 80h.
// - CAN mode byte bits 01h through 80h as defined.
//
// The register offsets and the plain strobed port were decided locally.
module fault_message_framer
    import fault_framer_pkg::*;
(
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [EVENT_COUNT-1:0] EVENT_I,
    input wire can_fault_type CAN_FAULT_I,
    input wire logic [7:0] MIN_DLC_I,
    input wire adc_fault_type ADC_FAULT_I,
    input wire logic [7:0] ERROR_REGISTER_I,
    input wire logic FRAME_READY_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WRITE_I,
    input wire logic READ_I,
    output logic [31:0] RDATA_O,
    output frame_type FRAME_O,
    output logic FRAME_VALID_O,
    output logic CAN_REINIT_O,
    output logic IRQ_O
);
    state_type r;
    state_type next_r;

    // Lowest numbered pending event wins.
    function automatic int pick(input logic [EVENT_COUNT-1:0] pend);
        int k;
        k = EVENT_COUNT;
        for (int i = EVENT_COUNT - 1; i >= 0; i--) begin
            if (pend[i]) begin
                k = i;
            end
        end
        return k;
    endfunction

    function automatic logic [7:0] adc_tag(input logic frontend, input logic [7:0] sub);
        return frontend ? (ADC_FRONTEND_BASE | sub) : sub;
    endfunction

    function automatic logic [7:0] bool8(input logic b);
        return b ? 8'h01 : 8'h00;
    endfunction

    logic [EVENT_COUNT-1:0] wclr;
    int sel;
    logic [15:0] code;
    logic [7:0][7:0] bytes;

    always_comb begin
        next_r = r;
        code = 16'h0000;
        bytes = '0;
        wclr = '0;
        sel = pick(EVENT_I);
        next_r.can_reinit = 1'b0;
        if (r.frame_valid && FRAME_READY_I) begin
            next_r.frame_valid = 1'b0;
            next_r.phase = IDLE;
        end
        if (!next_r.frame_valid && sel < EVENT_COUNT) begin
            case (sel)
                EV_CAN: begin
                    code = CODE_CAN_COMM;
                    bytes[3] = CAN_FAULT_I.int_flags & CANINT_MASK;
                    bytes[4] = CAN_FAULT_I.mode_status;
                    bytes[5] = CAN_FAULT_I.error_count;
                    bytes[6] = CAN_FAULT_I.busoff_count;
                end
                EV_OVERRUN: begin
                    code = CODE_OVERRUN;
                end
                EV_GUARD: begin
                    code = CODE_GUARD;
                    next_r.can_reinit = 1'b1;
                end
                EV_RPDO: begin
                    code = CODE_RPDO_SHORT;
                    bytes[3] = MIN_DLC_I;
                end
                EV_ADC_CONV: begin
                    code = CODE_ADC;
                    bytes[3] = adc_tag(ADC_FAULT_I.frontend, SUB_CONV);
                    bytes[4] = ADC_FAULT_I.channel;
                end
                EV_ADC_RESET: begin
                    code = CODE_ADC;
                    bytes[3] = adc_tag(ADC_FAULT_I.frontend, SUB_RESET);
                    bytes[5] = ADC_FAULT_I.detail & (RSTERR_VALID_NOT_SET | RSTERR_VALID_NOT_CLEARED
                        | RSTERR_BAD_OFFSET | RSTERR_BAD_GAIN);
                end
                EV_ADC_OFFSET: begin
                    code = CODE_ADC;
                    bytes[3] = adc_tag(ADC_FAULT_I.frontend, SUB_OFFSET);
                end
                EV_ADC_GAIN: begin
                    code = CODE_ADC;
                    bytes[3] = adc_tag(ADC_FAULT_I.frontend, SUB_GAIN);
                end
                EV_ADC_INIT: begin
                    code = CODE_ADC;
                    bytes[3] = adc_tag(ADC_FAULT_I.frontend, SUB_INIT);
                    bytes[4] = ADC_FAULT_I.detail;
                end
                default: begin
                    code = 16'h0000;
                end
            endcase
            bytes[0] = code[7:0];
            bytes[1] = code[15:8];
            bytes[2] = ERROR_REGISTER_I;
            bytes[7] = r.toggle ? TOGGLE_ON : TOGGLE_OFF;
            next_r.toggle = ~r.toggle;
            next_r.frame.id = EMCY_BASE_ID + {3'b000, r.node};
            next_r.frame.data = bytes;
            next_r.frame_valid = 1'b1;
            next_r.phase = SEND;
            next_r.count = r.count + 16'h0001;
            next_r.last_code = code;
        end
        if (WRITE_I) begin
            case (ADDR_I)
                REG_STATUS: wclr = WDATA_I[EVENT_COUNT-1:0];
                REG_MASK: next_r.mask = WDATA_I[EVENT_COUNT-1:0];
                REG_NODE: next_r.node = WDATA_I[7:0];
                default: wclr = '0;
            endcase
        end
        // Events arriving in a clear cycle still set their status bit.
        next_r.status = (r.status & ~wclr) | EVENT_I;
        next_r.rdata = 32'h0000_0000;
        if (READ_I) begin
            case (ADDR_I)
                REG_STATUS: next_r.rdata = {{(32-EVENT_COUNT){1'b0}}, r.status};
                REG_MASK: next_r.rdata = {{(32-EVENT_COUNT){1'b0}}, r.mask};
                REG_NODE: next_r.rdata = {24'h000000, r.node};
                REG_COUNT: next_r.rdata = {16'h0000, r.count};
                REG_LAST_CODE: next_r.rdata = {16'h0000, r.last_code};
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
        next_r.irq = |(next_r.status & next_r.mask);
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            r <= '0;
            r.phase <= IDLE;
            r.node <= NODE_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign RDATA_O = r.rdata;
    assign FRAME_O = r.frame;
    assign FRAME_VALID_O = r.frame_valid;
    assign CAN_REINIT_O = r.can_reinit;
    assign IRQ_O = r.irq;
endmodule

// ---- tb/fault_framer_asserts.sv ----
// Port checks for the emergency frame builder.
module fault_framer_asserts
    import fault_framer_pkg::*;
(
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [EVENT_COUNT-1:0] EVENT_I,
    input wire can_fault_type CAN_FAULT_I,
    input wire logic FRAME_READY_I,
    input wire logic READ_I,
    input wire logic [31:0] RDATA_O,
    input wire frame_type FRAME_O,
    input wire logic FRAME_VALID_O,
    input wire logic CAN_REINIT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    // Remembers the toggle of the last accepted frame.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            last <= 1'b1;
        end else if (FRAME_VALID_O && FRAME_READY_I) begin
            last <= FRAME_O.data[7][7];
        end
    end
    sequence taken_s;
        (|EVENT_I) && (!FRAME_VALID_O || FRAME_READY_I);
    endsequence
    sequence fresh_s;
        FRAME_VALID_O && (!$past(FRAME_VALID_O) || $past(FRAME_READY_I));
    endsequence
    chk_id_base: assert property (FRAME_VALID_O |-> FRAME_O.id >= EMCY_BASE_ID)
        else $error("id below base");
    chk_toggle_flip: assert property (fresh_s |-> FRAME_O.data[7] == (last ? TOGGLE_OFF : TOGGLE_ON))
        else $error("toggle wrong");
    chk_frame_cause: assert property (fresh_s |-> $past(|EVENT_I))
        else $error("frame without event");
    chk_event_frame: assert property (taken_s |=> FRAME_VALID_O)
        else $error("event lost");
    chk_frame_hold: assert property (FRAME_VALID_O && !FRAME_READY_I |=> FRAME_VALID_O && $stable(FRAME_O))
        else $error("frame not held");
    chk_can_bytes: assert property (taken_s ##0 EVENT_I[0] |=> FRAME_O.data[1:0] == CODE_CAN_COMM
        && FRAME_O.data[3] == ($past(CAN_FAULT_I.int_flags) & CANINT_MASK)) else $error("can bytes");
    chk_guard_reinit: assert property (taken_s ##0 EVENT_I[2:0] == 3'b100 |-> ##[1:2] CAN_REINIT_O)
        else $error("no reinit");
    chk_read_idle: assert property (!$past(READ_I) |-> RDATA_O == 32'h0)
        else $error("read data not idle");
endmodule
bind fault_message_framer fault_framer_asserts chk (.CLK_I, .NRST_I, .EVENT_I, .CAN_FAULT_I, .FRAME_READY_I,
    .READ_I, .RDATA_O, .FRAME_O, .FRAME_VALID_O, .CAN_REINIT_O);

// ---- tb/frame_sink.sv ----
// Host side consumer of emergency frames.
module frame_sink (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic stall_i,
    input wire logic slow_i,
    output logic ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk_i) begin
        ready_o <= nrst_i && !stall_i && (!slow_i || !ready_o);
    end
endmodule

// ---- tb/fault_message_framer_tb.sv ----
// Self-checking bench for the emergency frame builder.
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %h %h", $time, a, b); end end
module fault_message_framer_tb;
    import fault_framer_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [EVENT_COUNT-1:0] ev = '0;
    can_fault_type can = '0;
    adc_fault_type adc = '0;
    logic [7:0] dlc = 8'h00;
    logic [7:0] erreg = 8'h00;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic ready, fvalid, reinit, irq, tg = 1'b0;
    logic [31:0] rdata, rx, seed = 32'h24DE;
    logic [63:0] mx;
    frame_type frame, fx;
    frame_type fq[$];
    logic [63:0] mq[$];
    logic [31:0] rq[$];
    int fail_count = 0;
    int check_count = 0;
    always #12.5 clk = ~clk;
    frame_sink sink (.clk_i(clk), .nrst_i(nrst), .stall_i(stall), .slow_i(slow), .ready_o(ready));
    fault_message_framer uut (.CLK_I(clk), .NRST_I(nrst), .EVENT_I(ev), .CAN_FAULT_I(can), .MIN_DLC_I(dlc),
        .ADC_FAULT_I(adc), .ERROR_REGISTER_I(erreg), .FRAME_READY_I(ready), .ADDR_I(addr), .WDATA_I(wdata),
        .WRITE_I(wr), .READ_I(rd), .RDATA_O(rdata), .FRAME_O(frame), .FRAME_VALID_O(fvalid),
        .CAN_REINIT_O(reinit), .IRQ_O(irq));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wreg(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(logic [3:0] a, logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        rq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic send(logic [8:0] bits, bit take);
        int k;
        frame_type f;
        logic [63:0] m;
        logic [31:0] r;
        k = 0;
        while (!bits[k]) k++;
        seed = lfsr(seed);
        r = seed;
        @(negedge clk);
        while (take && fvalid) @(negedge clk);
        @(posedge clk);
        ev <= bits;
        can <= r;
        dlc <= r[7:0];
        adc <= {r[0], r[15:8], r[23:16]};
        erreg <= r[31:24];
        f.id = EMCY_BASE_ID + 11'h025;
        f.data = '0;
        f.data[1:0] = k == 0 ? CODE_CAN_COMM : k == 1 ? CODE_OVERRUN : k == 2 ? CODE_GUARD
            : k == 3 ? CODE_RPDO_SHORT : CODE_ADC;
        f.data[2] = r[31:24];
        m = k < 3 ? 64'hFF00000000FFFFFF : k == 3 ? 64'hFF000000FFFFFFFF
            : k < 6 ? 64'hFF00FFFFFFFFFFFF : 64'hFF0000FFFFFFFFFF;
        if (k == 0) begin
            f.data[6:3] = {r[7:0], r[15:8], r[23:16], r[31:24] & CANINT_MASK};
            m = '1;
        end else if (k == 3) begin
            f.data[3] = r[7:0];
        end else if (k > 3) begin
            f.data[3] = {1'b0, r[0], r[0], 5'(k - 3)};
            f.data[4] = k == 4 ? r[15:8] : k == 8 ? r[23:16] : 8'h00;
            f.data[5] = k == 5 ? (r[23:16] & 8'h0F) : 8'h00;
        end
        f.data[7] = tg ? TOGGLE_ON : TOGGLE_OFF;
        if (take) begin
            fq.push_back(f);
            mq.push_back(m);
            tg = ~tg;
        end
        @(posedge clk);
        ev <= '0;
    endtask
    always @(posedge clk) begin
        rd_d <= rd;
    end
    // Frames are compared mid-cycle, before the edge that hands them over, so the outputs are settled.
    always @(negedge clk) begin
        if (fvalid && ready) begin
            fx = fq.pop_front();
            mx = mq.pop_front();
            `CHK({frame.id, frame.data & mx}, {fx.id, fx.data & mx})
        end
        if (rd_d) begin
            rx = rq.pop_front();
            `CHK(rdata, rx)
        end
    end
    initial begin
        #100us;
        fail_count++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rreg(REG_NODE, {24'h0, NODE_RESET});
        wreg(REG_NODE, 32'h25);
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            for (int k = 0; k < EVENT_COUNT; k++) send(9'(1 << k), 1'b1);
        end
        @(posedge clk);
        stall <= 1'b1;
        send(9'h002, 1'b1);
        send(9'h004, 1'b0);
        @(posedge clk);
        stall <= 1'b0;
        send(9'h00C, 1'b1);
        repeat (6) @(posedge clk);
        rreg(REG_STATUS, 32'h1FF);
        @(negedge clk);
        `CHK(irq, 1'b0)
        wreg(REG_MASK, 32'h1FF);
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b1)
        wreg(REG_STATUS, 32'h1FF);
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b0)
        rreg(REG_STATUS, 32'h0);
        rreg(REG_COUNT, 32'd20);
        rreg(REG_LAST_CODE, {16'h0, CODE_GUARD});
        rreg(4'hF, 32'h0);
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule
